//--- i2cm_pkg.sv
/*
 * i2cm_pkg: register map, field positions, reset values, timing counts
 * and carrier types for the two-wire master engine.
 * assumes: APB slave with 32-bit data, one register per aligned word.
 */
package i2cm_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00; // port_control_one
   localparam logic [7:0] OFS_CTRL_TWO = 8'h04; // port_control_two
   localparam logic [7:0] OFS_STATUS   = 8'h08; // port_status_reg
   localparam logic [7:0] OFS_BUFFER   = 8'h0C; // shift_buffer
   localparam logic [7:0] OFS_DIVIDER  = 8'h10; // baud_divider_field

   // port_control_one fields
   localparam int CON1_MODE_LSB = 0;  // port_mode_select [3:0]
   localparam int CON1_ENABLE   = 5;  // port_enable_bit
   localparam int CON1_OVERFLOW = 6;  // receive_overflow_flag
   localparam int CON1_WRITE_COLLISION_FLAG     = 7;  // write_collision_flag
   localparam logic [3:0] MODE_MASTER = 4'h8;

   // port_control_two fields
   localparam int CON2_START   = 0;  // start_enable_bit
   localparam int CON2_RECEIVE = 3;  // receive_enable_bit
   localparam int CON2_ACKSEQ  = 4;  // ack_sequence_enable
   localparam int CON2_ACKDATA = 5;  // ack_data_bit
   localparam int CON2_ACK_STATUS_BIT = 6;  // ack_status_bit

   // port_status_reg fields
   localparam int STAT_FULL  = 0;  // buffer_full_flag
   localparam int STAT_START = 3;  // start seen
   localparam int STAT_STOP  = 4;  // stop seen
   localparam int STAT_IRQ   = 5;  // port_interrupt_flag
   localparam int STAT_BCOL  = 6;  // bus_collision_flag

   // reset values
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [6:0] RST_DIVIDER = 7'h00;

   // rewrite window: two instruction cycles of 4 oscillator periods
   localparam int RW_WINDOW_NS = 2 * 4 * 21;
   localparam int CLK_PERIOD_NS = 4;
   localparam logic [7:0] RW_WINDOW_CYC =
      8'((RW_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // apb request carrier
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } i2cm_req_t;

   // bus line carrier (synchronised pin levels)
   typedef struct packed {
      logic scl;
      logic sda;
   } i2cm_lines_t;

   // engine states, gray along the declaration order
   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_S_SETUP = 4'b0001,
      ST_S_HOLD  = 4'b0011,
      ST_TX_LOW  = 4'b0010,
      ST_TX_HIGH = 4'b0110,
      ST_RX_LOW  = 4'b0111,
      ST_RX_HIGH = 4'b0101,
      ST_AK_LOW  = 4'b0100,
      ST_AK_HIGH = 4'b1100,
      ST_AK_DONE = 4'b1101
   } i2cm_state_t;

endpackage : i2cm_pkg

//--- i2cm_engine.sv
/*
 * i2cm_engine: two-wire bus master engine with APB register access.
 * assumes: pins are open drain, resolved outside; scl/sda inputs are
 * asynchronous and pass two flops; pclk 250 MHz.
 */
// The register offsets and the APB interface to the registers were decided locally.
// Function
// R01: software selects master mode and enables port; pins then driven.
// R02: start-seen and stop-seen flags clear on reset or disable.
// R03: software starts only when stop seen or bus idle.
// R04: no queueing; buffer write during start sets write collision.
// R05: interrupt flag set on start, stop, byte, ack, repeated start. The code has no repeated start sequence.
// R06: start enable with lines high loads counter; timeout drives data low.
// R07: second timeout clears start enable, holds data low, start done.
// R08: lines low at start or clock low early: bus collision, abort.
// R09: low five control-two bits ignore writes until start completes.
// R10: buffer write sets buffer full and starts shifting the byte.
// R11: data changes after clock falls; clock low then high one period.
// R12: after eighth bit clear buffer full and release data line.
// R13: ninth clock fall samples data into ack status bit.
// R14: after ninth clock set interrupt, suspend counter, clock held low.
// R15: buffer write while shifting out sets collision; early rewrite updates.
// R16: receive enable honoured only while idle.
// R17: receive toggles clock each rollover, shifts sampled bits in.
// R18: after eighth receive fall copy byte, set full, interrupt, hold.
// R19: software read of buffer clears buffer full after reception.
// R20: byte received while buffer full sets receive overflow.
// R21: buffer write while shifting in sets collision, buffer unchanged.
// R22: software may request acknowledge after a received byte.
// R23: acknowledge drives ack data bit for one clock, then interrupt.
`timescale 1ns/1ps
module i2cm_engine
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe
);

   i2cm_pkg::i2cm_req_t   req;
   i2cm_pkg::i2cm_lines_t meta_r;
   i2cm_pkg::i2cm_lines_t line_r;
   i2cm_pkg::i2cm_lines_t line_q_r;
   i2cm_pkg::i2cm_state_t state_r;

   logic [3:0] mode_r;
   logic       enable_r;
   logic       write_collision_flag_r;
   logic       ovfl_r;
   logic       start_en_r;
   logic       rcv_en_r;
   logic       ack_en_r;
   logic       ack_data_r;
   logic       ack_stat_r;
   logic       full_r;
   logic       s_seen_r;
   logic       p_seen_r;
   logic       irq_r;
   logic       bcol_r;
   logic [6:0] divider_r;
   logic [7:0] buffer_r;
   logic [7:0] shift_r;
   logic [6:0] baud_r;
   logic [3:0] bit_r;
   logic [7:0] rw_cnt_r;
   logic       drive_scl_low_r;
   logic       drive_sda_low_r;
   logic       apb_done_r;

   logic       acc;
   logic       wr_acc;
   logic       rd_acc;
   logic       master_on;
   logic       tick;
   logic       busy;
   logic       buf_wr;
   logic       buf_wr_ok;
   logic       buf_wr_late;
   logic       con2_wr;
   logic       s_done;
   logic       tx_done;
   logic       rx_done;
   logic       ak_done;
   logic       bcol_evt;
   logic       start_evt;
   logic       stop_evt;

   // register address match
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   assign req       = '{wr: pwrite, addr: paddr, wdata: pwdata};
   assign acc       = psel && penable && !apb_done_r;
   assign wr_acc    = acc && req.wr;
   assign rd_acc    = acc && !req.wr;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         apb_done_r <= 1'b0;
      else
         apb_done_r <= acc;
   end

   // pin synchronisers, two flops each
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r   <= '{scl: 1'b1, sda: 1'b1};
         line_r   <= '{scl: 1'b1, sda: 1'b1};
         line_q_r <= '{scl: 1'b1, sda: 1'b1};
      end
      else
      begin
         meta_r   <= '{scl: scl_in, sda: sda_in};
         line_r   <= meta_r;
         line_q_r <= line_r;
      end
   end

   // R01: master mode only when selected and enabled
   assign master_on = enable_r && (mode_r == i2cm_pkg::MODE_MASTER);
   assign tick      = (baud_r == 7'h00);
   assign busy      = (state_r != i2cm_pkg::ST_IDLE);
   assign buf_wr    = wr_acc && hit(req.addr, i2cm_pkg::OFS_BUFFER);
   assign con2_wr   = wr_acc && hit(req.addr, i2cm_pkg::OFS_CTRL_TWO);
   // R15: rewrite inside the window still lands in the buffer
   assign buf_wr_late = buf_wr && (rw_cnt_r != 8'h00)
                        && (state_r == i2cm_pkg::ST_TX_LOW
                            || state_r == i2cm_pkg::ST_TX_HIGH);
   assign buf_wr_ok = buf_wr && master_on && !busy && !start_en_r;

   assign s_done  = (state_r == i2cm_pkg::ST_S_HOLD) && tick;
   assign tx_done = (state_r == i2cm_pkg::ST_TX_HIGH) && tick
                    && (bit_r == 4'd8);
   assign rx_done = (state_r == i2cm_pkg::ST_RX_HIGH) && tick
                    && (bit_r == 4'd7);
   assign ak_done = (state_r == i2cm_pkg::ST_AK_DONE);
   // R08: lines low at start, or clock low before data goes low
   assign bcol_evt = master_on &&
      ((state_r == i2cm_pkg::ST_IDLE && start_en_r
        && !line_r.scl && !line_r.sda)
       || (state_r == i2cm_pkg::ST_S_SETUP && !line_r.scl));

   // baud counter: reloads from divider, runs only while busy
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         baud_r <= 7'h00;
      else if (!busy || tick)
         baud_r <= divider_r;
      else
         baud_r <= baud_r - 7'h01;
   end

   // rewrite window counter after an accepted buffer write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rw_cnt_r <= 8'h00;
      else if (buf_wr_ok)
         rw_cnt_r <= i2cm_pkg::RW_WINDOW_CYC;
      else if (rw_cnt_r != 8'h00)
         rw_cnt_r <= rw_cnt_r - 8'h01;
   end

   // engine sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r         <= i2cm_pkg::ST_IDLE;
         bit_r           <= 4'h0;
         shift_r         <= i2cm_pkg::RST_BYTE;
         drive_scl_low_r <= 1'b0;
         drive_sda_low_r <= 1'b0;
      end
      else if (!master_on || bcol_evt)
      begin
         state_r         <= i2cm_pkg::ST_IDLE;
         drive_scl_low_r <= 1'b0;
         drive_sda_low_r <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            i2cm_pkg::ST_IDLE:
            begin
               // R06: both lines high, start timing
               if (start_en_r && line_r.scl && line_r.sda)
                  state_r <= i2cm_pkg::ST_S_SETUP;
               // R10: buffer write begins shifting the byte
               else if (buf_wr_ok)
               begin
                  shift_r         <= req.wdata[7:0];
                  bit_r           <= 4'h0;
                  drive_sda_low_r <= !req.wdata[7];
                  state_r         <= i2cm_pkg::ST_TX_LOW;
               end
               // R16: receive only from idle
               else if (rcv_en_r)
               begin
                  bit_r           <= 4'h0;
                  drive_sda_low_r <= 1'b0;
                  state_r         <= i2cm_pkg::ST_RX_LOW;
               end
               // R23: acknowledge drives ack data bit
               else if (ack_en_r)
               begin
                  drive_sda_low_r <= !ack_data_r;
                  state_r         <= i2cm_pkg::ST_AK_LOW;
               end
            end
            i2cm_pkg::ST_S_SETUP:
               // R06: timeout with lines high, data low
               if (tick && line_r.sda)
               begin
                  drive_sda_low_r <= 1'b1;
                  state_r         <= i2cm_pkg::ST_S_HOLD;
               end
            i2cm_pkg::ST_S_HOLD:
               // R07: second timeout finishes start, clock low
               if (tick)
               begin
                  drive_scl_low_r <= 1'b1;
                  state_r         <= i2cm_pkg::ST_IDLE;
               end
            i2cm_pkg::ST_TX_LOW:
            begin
               drive_scl_low_r <= 1'b1;
               // R15: early rewrite replaces the outgoing byte
               if (buf_wr_late && bit_r == 4'h0)
               begin
                  shift_r         <= req.wdata[7:0];
                  drive_sda_low_r <= !req.wdata[7];
               end
               // R11: clock low one period then release
               if (tick)
               begin
                  drive_scl_low_r <= 1'b0;
                  state_r         <= i2cm_pkg::ST_TX_HIGH;
               end
            end
            i2cm_pkg::ST_TX_HIGH:
               if (tick)
               begin
                  // R11: data changes after clock falls
                  drive_scl_low_r <= 1'b1;
                  bit_r           <= bit_r + 4'h1;
                  shift_r         <= {shift_r[6:0], 1'b0};
                  // R12: release data for ninth clock
                  drive_sda_low_r <= (bit_r < 4'd7) && !shift_r[6];
                  // R14: ninth clock done, hold clock low
                  state_r <= (bit_r == 4'd8) ? i2cm_pkg::ST_IDLE
                                             : i2cm_pkg::ST_TX_LOW;
               end
            i2cm_pkg::ST_RX_LOW:
            begin
               drive_scl_low_r <= 1'b1;
               // R17: toggle clock every rollover
               if (tick)
               begin
                  drive_scl_low_r <= 1'b0;
                  state_r         <= i2cm_pkg::ST_RX_HIGH;
               end
            end
            i2cm_pkg::ST_RX_HIGH:
               if (tick)
               begin
                  // R17: sample and shift on the fall
                  drive_scl_low_r <= 1'b1;
                  shift_r         <= {shift_r[6:0], line_r.sda};
                  bit_r           <= bit_r + 4'h1;
                  // R18: eighth fall ends reception
                  state_r <= (bit_r == 4'd7) ? i2cm_pkg::ST_IDLE
                                             : i2cm_pkg::ST_RX_LOW;
               end
            i2cm_pkg::ST_AK_LOW:
               if (tick)
               begin
                  drive_scl_low_r <= 1'b0;
                  state_r         <= i2cm_pkg::ST_AK_HIGH;
               end
            i2cm_pkg::ST_AK_HIGH:
               if (tick)
               begin
                  drive_scl_low_r <= 1'b1;
                  state_r         <= i2cm_pkg::ST_AK_DONE;
               end
            i2cm_pkg::ST_AK_DONE:
            begin
               drive_sda_low_r <= 1'b0;
               state_r         <= i2cm_pkg::ST_IDLE;
            end
            default:
               state_r <= i2cm_pkg::ST_IDLE;
         endcase
      end
   end

   // control registers and mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r    <= 4'h0;
         enable_r  <= 1'b0;
         divider_r <= i2cm_pkg::RST_DIVIDER;
      end
      else if (wr_acc && hit(req.addr, i2cm_pkg::OFS_CTRL_ONE))
      begin
         mode_r   <= req.wdata[i2cm_pkg::CON1_MODE_LSB +: 4];
         enable_r <= req.wdata[i2cm_pkg::CON1_ENABLE];
      end
      else if (wr_acc && hit(req.addr, i2cm_pkg::OFS_DIVIDER))
         divider_r <= req.wdata[6:0];
   end

   // sequence enables: hardware clear wins, writes blocked during start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_en_r <= 1'b0;
         rcv_en_r   <= 1'b0;
         ack_en_r   <= 1'b0;
         ack_data_r <= 1'b0;
      end
      else if (!master_on)
      begin
         start_en_r <= 1'b0;
         rcv_en_r   <= 1'b0;
         ack_en_r   <= 1'b0;
      end
      else
      begin
         // R09: lower bits locked until start completes
         if (con2_wr && !start_en_r)
         begin
            start_en_r <= req.wdata[i2cm_pkg::CON2_START];
            // R16: receive enable disregarded when not idle
            rcv_en_r   <= req.wdata[i2cm_pkg::CON2_RECEIVE] && !busy;
            ack_en_r   <= req.wdata[i2cm_pkg::CON2_ACKSEQ];
         end
         if (con2_wr)
            ack_data_r <= req.wdata[i2cm_pkg::CON2_ACKDATA];
         // R07: start enable cleared on completion
         if (s_done || bcol_evt)
            start_en_r <= 1'b0;
         // R18: receive enable cleared on entering ST_RX_LOW and after eighth bit
         if (rx_done || (state_r == i2cm_pkg::ST_RX_LOW))
            rcv_en_r <= 1'b0;
         if (ak_done || state_r == i2cm_pkg::ST_AK_LOW)
            ack_en_r <= 1'b0;
      end
   end

   // buffer contents
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         buffer_r <= i2cm_pkg::RST_BYTE;
      // R18: received byte lands in buffer
      else if (rx_done)
         buffer_r <= {shift_r[6:0], line_r.sda};
      // R15: accepted or early rewrite updates buffer
      else if (buf_wr_ok || buf_wr_late)
         buffer_r <= req.wdata[7:0];
   end

   // buffer full flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         full_r <= 1'b0;
      // R18: received byte sets full (set wins)
      else if (rx_done || buf_wr_ok)
         full_r <= 1'b1;
      // R12: cleared after eighth bit out
      else if (state_r == i2cm_pkg::ST_TX_HIGH && tick && bit_r == 4'd7)
         full_r <= 1'b0;
      // R19: reading the buffer clears full
      else if (rd_acc && hit(req.addr, i2cm_pkg::OFS_BUFFER))
         full_r <= 1'b0;
   end

   // ack status sampled on ninth clock fall
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ack_stat_r <= 1'b0;
      // R13: low means acknowledged
      else if (tx_done)
         ack_stat_r <= line_r.sda;
   end

   // sticky event flags; set wins over software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         write_collision_flag_r <= 1'b0;
         ovfl_r <= 1'b0;
         irq_r  <= 1'b0;
         bcol_r <= 1'b0;
      end
      else
      begin
         if (wr_acc && hit(req.addr, i2cm_pkg::OFS_CTRL_ONE))
         begin
            write_collision_flag_r <= req.wdata[i2cm_pkg::CON1_WRITE_COLLISION_FLAG] && write_collision_flag_r;
            ovfl_r <= req.wdata[i2cm_pkg::CON1_OVERFLOW] && ovfl_r;
         end
         if (wr_acc && hit(req.addr, i2cm_pkg::OFS_STATUS))
         begin
            irq_r  <= req.wdata[i2cm_pkg::STAT_IRQ] && irq_r;
            bcol_r <= req.wdata[i2cm_pkg::STAT_BCOL] && bcol_r;
         end
         // R04: R15: R21: write while busy or starting collides
         if (buf_wr && master_on && (busy || start_en_r))
            write_collision_flag_r <= 1'b1;
         // R20: byte in while buffer still full
         if (rx_done && full_r)
            ovfl_r <= 1'b1;
         // R05: R14: R18: R23: interrupt on start, byte, ack
         if (s_done || tx_done || rx_done || ak_done || stop_evt)
            irq_r <= 1'b1;
         // R08: bus collision flag
         if (bcol_evt)
            bcol_r <= 1'b1;
      end
   end

   // bus condition monitor: data edges while clock high
   assign start_evt = line_q_r.sda && !line_r.sda && line_r.scl
                      && line_q_r.scl;
   assign stop_evt  = master_on && !line_q_r.sda && line_r.sda
                      && line_r.scl && line_q_r.scl;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_seen_r <= 1'b0;
         p_seen_r <= 1'b0;
      end
      // R02: cleared when module disabled
      else if (!enable_r)
      begin
         s_seen_r <= 1'b0;
         p_seen_r <= 1'b0;
      end
      else if (start_evt)
      begin
         s_seen_r <= 1'b1;
         p_seen_r <= 1'b0;
      end
      else if (stop_evt)
      begin
         s_seen_r <= 1'b0;
         p_seen_r <= 1'b1;
      end
   end

   // apb answer and read mux
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= acc;
         pslverr <= acc && (req.addr > i2cm_pkg::OFS_DIVIDER
                            || req.addr[1:0] != 2'b00);
         prdata  <= 32'h0000_0000;
         if (rd_acc)
            unique case (req.addr)
               i2cm_pkg::OFS_CTRL_ONE:
                  prdata[7:0] <= {write_collision_flag_r, ovfl_r, enable_r, 1'b0, mode_r};
               i2cm_pkg::OFS_CTRL_TWO:
                  prdata[7:0] <= {1'b0, ack_stat_r, ack_data_r, ack_en_r,
                                  rcv_en_r, 2'b00, start_en_r};
               i2cm_pkg::OFS_STATUS:
                  prdata[7:0] <= {1'b0, bcol_r, irq_r, p_seen_r,
                                  s_seen_r, 2'b00, full_r};
               i2cm_pkg::OFS_BUFFER:
                  prdata[7:0] <= buffer_r;
               i2cm_pkg::OFS_DIVIDER:
                  prdata[7:0] <= {1'b0, divider_r};
               default:
                  prdata <= 32'h0000_0000;
            endcase
      end
   end

   // R01: open-drain pins, only pulled low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_out <= 1'b0;
         scl_oe  <= 1'b0;
         sda_out <= 1'b0;
         sda_oe  <= 1'b0;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe  <= master_on && drive_scl_low_r;
         sda_oe  <= master_on && drive_sda_low_r;
      end
   end

endmodule : i2cm_engine

//--- i2cm_props.sv
/* i2cm_props: port checker for the two-wire master engine.
   assumes: bound to i2cm_engine, single clock, reset low. */
`timescale 1ns/1ps
module i2cm_props
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_in,
   input wire logic        scl_out,
   input wire logic        scl_oe,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // bus answer timing and shape
   wait_state_a: assert property ($rose(penable) && psel |=> pready)
      else $error("answer not one cycle after access");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property (pready |-> psel && $past(penable))
      else $error("ready without access");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_err_a: assert property
      ($rose(penable) && psel && paddr == 8'h14 |=> pslverr)
      else $error("unmapped access not refused");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   open_drain_a: assert property (!scl_out && !sda_out)
      else $error("pin driven high");
   sda_release_a: assert property ($fell(sda_oe) |-> scl_oe)
      else $error("data released while clock high");
   // main scenarios
   cover property (pslverr);
   cover property ($rose(sda_oe) && !scl_oe);
   cover property ($fell(scl_oe));
endmodule : i2cm_props

bind i2cm_engine i2cm_props u_props
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe)
);

//--- i2cm_slave_model.sv
/* i2cm_slave_model: behavioural slave on the two wires.
   assumes: open-drain lines with pull-ups resolved by the bench. */
`timescale 1ns/1ps
module i2cm_slave_model
(
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nack,
   input  wire logic       rx_mode,
   input  wire logic [7:0] rx_byte,
   output logic            sda_oe
);
   int unsigned bit_cnt = 9;
   // start seen: next clock fall opens a byte
   always @(negedge sda)
      if (scl)
         bit_cnt = 8;
   // count clock falls, nine to a byte
   always @(negedge scl)
      bit_cnt = (bit_cnt >= 8) ? 0 : bit_cnt + 1;
   // ack in ninth clock, or send data msb first
   always_comb
      if (rx_mode)
         sda_oe = bit_cnt < 8 && !rx_byte[7 - bit_cnt];
      else
         sda_oe = bit_cnt == 8 && !nack;
endmodule : i2cm_slave_model

//--- i2c_master_engine_tb_top.sv
/* i2c_master_engine_tb_top: register-level tests of the master engine.
   assumes: slave model on the wires, pull-ups on both lines. */
`timescale 1ns/1ps
module i2c_master_engine_tb_top;
   localparam logic [7:0] a_c1 = i2cm_pkg::OFS_CTRL_ONE;
   localparam logic [7:0] a_c2 = i2cm_pkg::OFS_CTRL_TWO;
   localparam logic [7:0] a_st = i2cm_pkg::OFS_STATUS;
   localparam logic [7:0] a_buf = i2cm_pkg::OFS_BUFFER;
   localparam logic [7:0] rx_val = 8'h96;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, scl_oe, sda_oe, s_oe;
   logic        nack = 0, rx_mode = 0;
   wire         scl = !scl_oe;
   wire         sda = !(sda_oe || s_oe);
   int          mismatches = 0, total_checks = 0;

   i2cm_engine DUT
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe)
   );
   i2cm_slave_model u_slave
   (
      .scl(scl), .sda(sda), .nack(nack), .rx_mode(rx_mode),
      .rx_byte(rx_val), .sda_oe(s_oe)
   );

   // clock, 4 ns period
   always #2 pclk = ~pclk;

   // one apb transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // poll status until the interrupt flag rises
   task automatic wait_irq;
      repeat (300)
      begin
         apb(1'b0, a_st, 32'h0);
         if (rd[i2cm_pkg::STAT_IRQ] === 1'b1)
            break;
      end
      check("irq", 1'b1, rd[5]);
   endtask : wait_irq

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   // watchdog
   initial
   begin
      #200000;
      mismatches++;
      end_sim();
   end

   // test sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, a_st, 32'h0);
      check("status rst", 32'h0, rd);
      apb(1'b0, 8'h14, 32'h0);
      check("unmapped", 32'h1, {rd[31:1], err});
      apb(1'b1, i2cm_pkg::OFS_DIVIDER, 32'h03);
      apb(1'b1, a_c1, 32'h28);
      apb(1'b1, a_c2, 32'h01);
      apb(1'b1, a_buf, 32'hA5);
      wait_irq();
      check("start seen", 1'b1, rd[3]);
      apb(1'b0, a_c1, 32'h0);
      check("write_collision_flag start", 1'b1, rd[7]);
      apb(1'b0, a_c2, 32'h0);
      check("start end", 1'b0, rd[0]);
      $display("test start done");
      apb(1'b1, a_c1, 32'h28);
      apb(1'b1, a_st, 32'h0);
      apb(1'b1, a_buf, 32'h5A);
      apb(1'b0, a_st, 32'h0);
      check("full tx", 1'b1, rd[0]);
      apb(1'b1, a_buf, 32'h33);
      wait_irq();
      check("full sent", 1'b0, rd[0]);
      apb(1'b0, a_c1, 32'h0);
      check("write_collision_flag tx", 1'b1, rd[7]);
      for (int n = 0; n < 2; n++)
      begin
         nack <= n[0];
         apb(1'b1, a_st, 32'h0);
         apb(1'b1, a_buf, 32'hC3);
         wait_irq();
         apb(1'b0, a_c2, 32'h0);
         check("ack_status_bit", n[0], rd[6]);
      end
      $display("test transmit done");
      rx_mode <= 1'b1;
      apb(1'b1, a_c1, 32'h28);
      apb(1'b1, a_st, 32'h0);
      apb(1'b1, a_c2, 32'h08);
      apb(1'b1, a_buf, 32'h11);
      wait_irq();
      check("full rx", 1'b1, rd[0]);
      apb(1'b0, a_c2, 32'h0);
      check("rcv end", 1'b0, rd[3]);
      apb(1'b0, a_c1, 32'h0);
      check("write_collision_flag rx", 1'b1, rd[7]);
      apb(1'b0, a_buf, 32'h0);
      check("rx byte", {24'h0, rx_val}, rd);
      apb(1'b0, a_st, 32'h0);
      check("full read", 1'b0, rd[0]);
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, a_st, 32'h0);
         apb(1'b1, a_c2, 32'h08);
         wait_irq();
      end
      apb(1'b0, a_c1, 32'h0);
      check("overflow", 1'b1, rd[6]);
      apb(1'b1, a_st, 32'h0);
      apb(1'b1, a_c2, 32'h10);
      wait_irq();
      $display("test receive done");
      apb(1'b1, a_c1, 32'h0);
      apb(1'b0, a_st, 32'h0);
      check("disabled", 2'b00, rd[4:3]);
      $display("test disable done");
      end_sim();
   end
endmodule : i2c_master_engine_tb_top
